/* File: hw/frc_timer.sv */
// Free-running 16-bit capture/compare timer with an AHB-Lite register port
`timescale 1ns/1ps
`default_nettype none

module frc_timer
  import frc_timer_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [31:0] HRDATA,
  output logic HRESP,
  input wire logic CAPTURE_PIN,
  output logic COMPARE_PIN,
  input wire logic STOP_MODE,
  output logic TIMER_IRQ
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  state_type s_reg;
  state_type s_next;
  keep_type k_reg;
  keep_type k_next;

  logic tick;
  logic pin_edge;
  logic tof_set;
  logic ocf_set;
  logic icf_set;
  logic cap_load;
  logic flags_access;
  logic [2:0] clr_vec;
  logic [15:0] count_inc;
  logic [7:0] rbyte;
  logic rd;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    k_next = k_reg;
    s_next.resp = 1'b0;
    count_inc = s_reg.count + COUNT_ONE;
    rd = s_reg.acc_pend & ~s_reg.acc_write;
    rbyte = BYTE_ZERO;

    // Capture pin synchroniser, then an edge detector on the later stages
    s_next.pin_s1 = CAPTURE_PIN;
    s_next.pin_s2 = s_reg.pin_s1;
    s_next.pin_s3 = s_reg.pin_s2;
    pin_edge = s_reg.edge_rise ? (s_reg.pin_s2 & ~s_reg.pin_s3)
                               : (~s_reg.pin_s2 & s_reg.pin_s3);

    // Prescaler and counter
    tick = s_reg.run & ~STOP_MODE & (s_reg.presc == PRESC_LAST);
    if (!s_reg.run) begin
      s_next.count = COUNT_PRESET;
      s_next.presc = 2'h0;
    end else if (STOP_MODE) begin
      s_next.presc = 2'h0;
    end else begin
      s_next.presc = s_reg.presc + PRESC_ONE;
      if (tick) begin
        s_next.count = count_inc;
      end
    end

    // Flag-setting events
    tof_set = tick & (s_reg.count == COUNT_MAX);
    ocf_set = tick & ~s_reg.cmp_inh & (count_inc == k_reg.compare);
    cap_load = pin_edge & s_reg.run & ~s_reg.cap_inh
               & ~(STOP_MODE & s_reg.stop_pend);
    icf_set = pin_edge & s_reg.run & ~STOP_MODE;

    // Compare match drives the level onto the pin whatever the flag
    if (ocf_set) begin
      s_next.pin_out = s_reg.level;
    end

    // Capture the count plus one to cover the synchroniser delay
    if (cap_load) begin
      k_next.capture = count_inc;
    end

    // Edges during stop arm a flag that appears once stop ends
    s_next.stop_d = STOP_MODE;
    if (STOP_MODE && pin_edge && s_reg.run) begin
      s_next.stop_pend = 1'b1;
    end else if (s_reg.stop_d && !STOP_MODE) begin
      s_next.stop_pend = 1'b0;
    end

    // Address phase capture; one wait state before every answer
    s_next.ready = 1'b1;
    s_next.acc_pend = 1'b0;
    if (!s_reg.acc_pend && HSEL && HTRANS[1] && HREADY) begin
      s_next.acc_pend = 1'b1;
      s_next.acc_write = HWRITE;
      s_next.acc_idx = (HSIZE == HSIZE_WORD) ? HADDR[9:2] : IDX_NONE;
      s_next.ready = 1'b0;
    end

    // Data phase: register access and its side effects
    flags_access = s_reg.acc_pend & (s_reg.acc_idx == IDX_FLAGS);
    clr_vec = 3'h0;
    if (s_reg.acc_pend) begin
      case (s_reg.acc_idx)
        IDX_CONTROL: begin
          rbyte = {s_reg.cap_ie, s_reg.cmp_ie, s_reg.ovf_ie, 2'h0,
                   s_reg.run, s_reg.edge_rise, s_reg.level};
          if (s_reg.acc_write) begin
            s_next.cap_ie = HWDATA[CTL_CAP_IRQ_EN];
            s_next.cmp_ie = HWDATA[CTL_CMP_IRQ_EN];
            s_next.ovf_ie = HWDATA[CTL_OVF_IRQ_EN];
            s_next.run = HWDATA[CTL_RUN];
            s_next.edge_rise = HWDATA[CTL_EDGE];
            s_next.level = HWDATA[CTL_LEVEL];
          end
        end
        IDX_FLAGS: begin
          rbyte = {s_reg.capture_flag, s_reg.compare_flag,
                   s_reg.overflow_flag, 5'h00};
        end
        IDX_CAP_HI: begin
          rbyte = k_reg.capture[15:8];
          if (rd) begin
            s_next.cap_inh = 1'b1;
          end
        end
        IDX_CAP_LO: begin
          rbyte = k_reg.capture[7:0];
          clr_vec[2] = s_reg.armed[2];
          if (rd) begin
            s_next.cap_inh = 1'b0;
          end
        end
        IDX_CMP_HI: begin
          rbyte = k_reg.compare[15:8];
          if (s_reg.acc_write) begin
            k_next.compare[15:8] = HWDATA[7:0];
            s_next.cmp_inh = 1'b1;
          end
        end
        IDX_CMP_LO: begin
          rbyte = k_reg.compare[7:0];
          clr_vec[1] = s_reg.armed[1];
          if (s_reg.acc_write) begin
            k_next.compare[7:0] = HWDATA[7:0];
            s_next.cmp_inh = 1'b0;
          end
        end
        IDX_CNT_HI, IDX_ALT_HI: begin
          rbyte = s_reg.count[15:8];
          if (rd && !s_reg.buf_valid) begin
            s_next.cnt_buf = s_reg.count[7:0];
            s_next.buf_valid = 1'b1;
          end
        end
        IDX_CNT_LO, IDX_ALT_LO: begin
          rbyte = s_reg.buf_valid ? s_reg.cnt_buf : s_reg.count[7:0];
          if (s_reg.acc_idx == IDX_CNT_LO) begin
            clr_vec[0] = s_reg.armed[0];
          end
          if (rd) begin
            s_next.buf_valid = 1'b0;
          end
        end
        default: begin
          rbyte = BYTE_ZERO;
        end
      endcase
      s_next.rdata = rd ? {24'h00_0000, rbyte} : WORD_ZERO;
    end

    // Flags: a set in the clearing cycle wins
    s_next.overflow_flag = (s_reg.overflow_flag & ~clr_vec[0]) | tof_set;
    s_next.compare_flag = (s_reg.compare_flag & ~clr_vec[1]) | ocf_set;
    s_next.capture_flag = (s_reg.capture_flag & ~clr_vec[2]) | icf_set
                          | (s_reg.stop_pend & s_reg.stop_d & ~STOP_MODE);
    if (flags_access) begin
      s_next.armed = {s_reg.capture_flag, s_reg.compare_flag,
                      s_reg.overflow_flag};
    end else begin
      s_next.armed = s_reg.armed & ~clr_vec;
    end

    // One registered interrupt from the enabled flags
    s_next.irq = (s_next.capture_flag & s_reg.cap_ie)
                 | (s_next.compare_flag & s_reg.cmp_ie)
                 | (s_next.overflow_flag & s_reg.ovf_ie);
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Control state with asynchronous reset
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      s_reg <= '0;
      s_reg.count <= COUNT_PRESET;
      s_reg.pin_out <= 1'b0;
      s_reg.ready <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Compare and capture values survive reset
  always_ff @(posedge REF_CLK) begin
    k_reg <= k_next;
  end

  // Outputs straight from flip-flops
  assign HREADYOUT = s_reg.ready;
  assign HRDATA = s_reg.rdata;
  assign HRESP = s_reg.resp;
  assign COMPARE_PIN = s_reg.pin_out;
  assign TIMER_IRQ = s_reg.irq;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RSTN);

  a_count_step: assert property (
    s_reg.run && $past(s_reg.run) && !$past(STOP_MODE)
      && (s_reg.count != $past(s_reg.count))
      |-> $past(s_reg.presc) == PRESC_LAST)
    else $error("counter moved off the prescaler boundary");

  a_idle_preset: assert property (
    !s_reg.run |=> s_reg.count == COUNT_PRESET)
    else $error("stopped timer left the preset value");

  a_overflow_set: assert property (
    tof_set |=> s_reg.overflow_flag && s_reg.count == 16'h0000)
    else $error("wrap did not set the overflow flag");

  a_compare_pin: assert property (
    ocf_set |=> COMPARE_PIN == $past(s_reg.level)
      && s_reg.compare_flag)
    else $error("match did not load the compare level");

  a_compare_hold: assert property (
    s_reg.cmp_inh && !(s_reg.acc_pend && s_reg.acc_idx == IDX_CMP_LO)
      |=> !$past(ocf_set) ##0 $stable(COMPARE_PIN))
    else $error("inhibited compare still matched");

  a_capture_plus: assert property (
    cap_load |=> k_reg.capture == $past(s_reg.count) + COUNT_ONE)
    else $error("capture is not count plus one");

  a_capture_block: assert property (
    s_reg.cap_inh && pin_edge |=> $stable(k_reg.capture))
    else $error("blocked capture changed the register");

  a_status_zero: assert property (
    rd && s_reg.acc_idx == IDX_FLAGS |=> HRDATA[4:0] == 5'h00
      && HREADYOUT)
    else $error("status low bits not zero");

  a_irq_follows: assert property (
    s_reg.overflow_flag && s_reg.ovf_ie
      ##1 s_reg.ovf_ie && s_reg.overflow_flag
      |-> TIMER_IRQ)
    else $error("enabled overflow flag raised no interrupt");

  a_overflow_clear: assert property (
    s_reg.armed[0] && s_reg.acc_pend && s_reg.acc_idx == IDX_CNT_LO
      && !tof_set |=> !s_reg.overflow_flag)
    else $error("overflow flag survived its clear sequence");

endmodule : frc_timer

`default_nettype wire

/* File: hw/frc_timer_pkg.sv */
// Constants and carrier types for the free-running capture/compare timer
package frc_timer_pkg;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_CONTROL = 8'h12;
  localparam logic [7:0] IDX_FLAGS = 8'h13;
  localparam logic [7:0] IDX_CAP_HI = 8'h14;
  localparam logic [7:0] IDX_CAP_LO = 8'h15;
  localparam logic [7:0] IDX_CMP_HI = 8'h16;
  localparam logic [7:0] IDX_CMP_LO = 8'h17;
  localparam logic [7:0] IDX_CNT_HI = 8'h18;
  localparam logic [7:0] IDX_CNT_LO = 8'h19;
  localparam logic [7:0] IDX_ALT_HI = 8'h1A;
  localparam logic [7:0] IDX_ALT_LO = 8'h1B;
  localparam logic [7:0] IDX_NONE = 8'hFF;

  // ----------------------------------------------------------------------
  // Field positions in timer_control and timer_flags
  // ----------------------------------------------------------------------
  localparam int CTL_CAP_IRQ_EN = 7;
  localparam int CTL_CMP_IRQ_EN = 6;
  localparam int CTL_OVF_IRQ_EN = 5;
  localparam int CTL_RUN = 2;
  localparam int CTL_EDGE = 1;
  localparam int CTL_LEVEL = 0;
  localparam int FLG_CAPTURE = 7;
  localparam int FLG_COMPARE = 6;
  localparam int FLG_OVERFLOW = 5;

  // ----------------------------------------------------------------------
  // Reset values and counter constants
  // ----------------------------------------------------------------------
  localparam logic [15:0] COUNT_PRESET = 16'hFFFC;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [1:0] PRESC_LAST = 2'h3;
  localparam logic [1:0] PRESC_ONE = 2'h1;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ----------------------------------------------------------------------
  // State carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] presc;
    logic [15:0] count;
    logic [7:0] cnt_buf;
    logic buf_valid;
    logic cmp_inh;
    logic cap_inh;
    logic run;
    logic edge_rise;
    logic level;
    logic cap_ie;
    logic cmp_ie;
    logic ovf_ie;
    logic capture_flag;
    logic compare_flag;
    logic overflow_flag;
    logic [2:0] armed;
    logic stop_pend;
    logic stop_d;
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;
    logic pin_out;
    logic irq;
    logic acc_pend;
    logic acc_write;
    logic [7:0] acc_idx;
    logic [31:0] rdata;
    logic ready;
    logic resp;
  } state_type;

  // Values that reset must leave alone
  typedef struct packed {
    logic [15:0] compare;
    logic [15:0] capture;
  } keep_type;

endpackage : frc_timer_pkg

/* File: test/frc_timer_test.sv */
// Self-checking bench for the capture/compare timer
`timescale 1ns/1ps
`default_nettype none

module frc_timer_test
  import frc_timer_pkg::*;
;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic REF_CLK, RSTN, HSEL, HWRITE, CAPTURE_PIN, STOP_MODE, e;
  logic [31:0] HADDR, HWDATA;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE;
  wire logic HREADY, HREADYOUT, HRESP, COMPARE_PIN, TIMER_IRQ;
  wire logic [31:0] HRDATA;
  int n_fail, compares, i;
  logic [7:0] d, a, b, c, h;
  logic [15:0] t;

  // Single slave, so its ready is the bus ready
  assign HREADY = HREADYOUT;

  frc_timer u_dut (
    .REF_CLK(REF_CLK), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
    .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRDATA(HRDATA),
    .HRESP(HRESP), .CAPTURE_PIN(CAPTURE_PIN), .COMPARE_PIN(COMPARE_PIN),
    .STOP_MODE(STOP_MODE), .TIMER_IRQ(TIMER_IRQ)
  );

  // Clock, 50 ns period
  initial begin
    REF_CLK = 1'b0;
    forever #25 REF_CLK = ~REF_CLK;
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Compare and report
  task automatic chk(input logic [7:0] s, input logic [7:0] x);
    compares++;
    if (s !== x) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : chk

  // Verdict and end of run
  task automatic end_sim;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  // One edge of a bounded wait; a spent bound ends the run
  task automatic tick(inout int n);
    @(posedge REF_CLK);
    n++;
    if (n > 400) begin
      n_fail++;
      end_sim;
    end
  endtask : tick

  // One AHB-Lite single word transfer
  task automatic xfer(input logic w, input logic [7:0] x,
                      input logic [7:0] wd, output logic [7:0] rv);
    int n;
    n = 0;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {22'h0, x, 2'h0};
    tick(n);
    while (HREADY !== 1'b1) tick(n);
    HTRANS <= 2'h0;
    HWDATA <= {24'h00_0000, wd};
    tick(n);
    while (HREADY !== 1'b1) tick(n);
    rv = HRDATA[7:0];
  endtask : xfer

  task automatic rd(input logic [7:0] x, output logic [7:0] v);
    xfer(1'b0, x, 8'h00, v);
  endtask : rd

  task automatic wr(input logic [7:0] x, input logic [7:0] v);
    logic [7:0] u;
    xfer(1'b1, x, v, u);
  endtask : wr

  task automatic idle(input int k);
    repeat (k) @(posedge REF_CLK);
  endtask : idle

  // Control byte from its fields
  function automatic logic [7:0] ctl(input logic ci, oi, vi, r, g, l);
    return {ci, oi, vi, 2'h0, r, g, l};
  endfunction : ctl

  // One when a capture lies one or two counts past the base
  function automatic logic [7:0] near(input logic [7:0] s, base);
    logic [7:0] df;
    df = s - base;
    return {7'h00, df == 8'h01 || df == 8'h02};
  endfunction : near

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    HSEL = 1'b1;
    HADDR = WORD_ZERO;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HSIZE = HSIZE_WORD;
    HWDATA = WORD_ZERO;
    CAPTURE_PIN = 1'b0;
    STOP_MODE = 1'b0;
    RSTN = 1'b0;
    n_fail = 0;
    compares = 0;
    i = $urandom(77);
    repeat (12) @(posedge REF_CLK);
    RSTN <= 1'b1;
    // Reset state, read-only flags, unmapped index
    chk({7'h00, COMPARE_PIN}, 8'h00);
    chk({7'h00, TIMER_IRQ}, 8'h00);
    rd(IDX_CONTROL, d);
    chk(d, 8'h00);
    wr(IDX_FLAGS, 8'hFF);
    wr(IDX_NONE, 8'hFF);
    rd(IDX_FLAGS, d);
    chk(d, 8'h00);
    rd(IDX_NONE, d);
    chk(d, 8'h00);
    rd(IDX_ALT_LO, d);
    idle(20);
    rd(IDX_CNT_HI, h);
    chk(h, 8'hFF);
    chk(d, 8'hFC);
    rd(IDX_CNT_LO, b);
    chk(b, 8'hFC);
    $display("test 1 done");
    // Compare bytes written one at a time
    h = 8'($urandom());
    b = 8'($urandom());
    wr(IDX_CMP_HI, h);
    wr(IDX_CMP_LO, b);
    wr(IDX_CMP_HI, ~h);
    rd(IDX_CMP_LO, d);
    chk(d, b);
    rd(IDX_CMP_HI, d);
    chk(d, ~h);
    wr(IDX_CMP_HI, 8'h80);
    wr(IDX_CMP_LO, 8'h00);
    $display("test 2 done");
    // Counting, wrap, buffered and alternate reads
    wr(IDX_CONTROL, ctl(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0));
    idle(40);
    rd(IDX_FLAGS, d);
    chk(d, 8'h20);
    chk({7'h00, TIMER_IRQ}, 8'h01);
    rd(IDX_ALT_LO, a);
    idle(9);
    rd(IDX_ALT_LO, d);
    chk(d, a + 8'h03);
    rd(IDX_FLAGS, d);
    chk(d, 8'h20);
    rd(IDX_ALT_LO, a);
    idle(9);
    rd(IDX_CNT_HI, d);
    idle(9);
    rd(IDX_ALT_HI, d);
    idle(9);
    rd(IDX_CNT_LO, d);
    chk(d, a + 8'h03);
    rd(IDX_FLAGS, d);
    chk(d, 8'h00);
    chk({7'h00, TIMER_IRQ}, 8'h00);
    $display("test 3 done");
    // Compare match, level, masking, flag clear, inhibit
    rd(IDX_CNT_HI, h);
    rd(IDX_CNT_LO, b);
    t = {h, b} + 16'h0030;
    wr(IDX_CONTROL, ctl(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1));
    wr(IDX_CMP_HI, t[15:8]);
    wr(IDX_CMP_LO, t[7:0]);
    i = 0;
    while (COMPARE_PIN !== 1'b1) tick(i);
    rd(IDX_FLAGS, d);
    chk(d, 8'h40);
    chk({7'h00, TIMER_IRQ}, 8'h01);
    wr(IDX_CONTROL, ctl(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1));
    idle(2);
    chk({7'h00, TIMER_IRQ}, 8'h00);
    rd(IDX_CMP_LO, d);
    rd(IDX_FLAGS, d);
    chk(d, 8'h00);
    rd(IDX_CNT_HI, h);
    rd(IDX_CNT_LO, b);
    t = {h, b} + 16'h0030;
    wr(IDX_CMP_LO, t[7:0]);
    wr(IDX_CMP_HI, t[15:8]);
    wr(IDX_CONTROL, ctl(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0));
    idle(300);
    chk({7'h00, COMPARE_PIN}, 8'h01);
    rd(IDX_FLAGS, d);
    wr(IDX_CMP_LO, t[7:0]);
    $display("test 4 done");
    // Capture on each edge select
    for (i = 0; i < 2; i++) begin
      e = i[0];
      wr(IDX_CONTROL, ctl(1'b1, 1'b0, 1'b0, 1'b1, e, 1'b0));
      CAPTURE_PIN <= e;
      idle(8);
      rd(IDX_FLAGS, d);
      rd(IDX_CAP_LO, d);
      CAPTURE_PIN <= ~e;
      idle(8);
      rd(IDX_FLAGS, d);
      chk(d, 8'h00);
      chk({7'h00, TIMER_IRQ}, 8'h00);
      rd(IDX_ALT_LO, a);
      CAPTURE_PIN <= e;
      idle(8);
      rd(IDX_FLAGS, d);
      chk(d, 8'h80);
      chk({7'h00, TIMER_IRQ}, 8'h01);
      rd(IDX_CAP_LO, c);
      chk(near(c, a), 8'h01);
    end
    // High read blocks, low read alone does not
    rd(IDX_CAP_HI, h);
    CAPTURE_PIN <= 1'b0;
    idle(8);
    CAPTURE_PIN <= 1'b1;
    idle(8);
    rd(IDX_FLAGS, d);
    chk(d, 8'h80);
    rd(IDX_CAP_LO, d);
    chk(d, c);
    CAPTURE_PIN <= 1'b0;
    idle(8);
    CAPTURE_PIN <= 1'b1;
    idle(8);
    rd(IDX_CAP_LO, d);
    CAPTURE_PIN <= 1'b0;
    idle(8);
    rd(IDX_ALT_LO, a);
    CAPTURE_PIN <= 1'b1;
    idle(8);
    rd(IDX_CAP_LO, d);
    chk(near(d, a), 8'h01);
    $display("test 5 done");
    // Stop holds the count, run off presets it
    STOP_MODE <= 1'b1;
    idle(4);
    rd(IDX_ALT_LO, a);
    idle(9);
    rd(IDX_ALT_LO, d);
    chk(d, a);
    // An edge in stop loads the capture; its flag waits for stop to end
    rd(IDX_FLAGS, d);
    rd(IDX_CAP_LO, d);
    CAPTURE_PIN <= 1'b0;
    idle(8);
    CAPTURE_PIN <= 1'b1;
    idle(8);
    rd(IDX_FLAGS, d);
    chk(d, 8'h00);
    STOP_MODE <= 1'b0;
    idle(4);
    rd(IDX_CAP_LO, c);
    chk(c, a + 8'h01);
    rd(IDX_FLAGS, d);
    chk(d, 8'h80);
    wr(IDX_CONTROL, 8'h00);
    rd(IDX_CNT_HI, h);
    rd(IDX_CNT_LO, b);
    chk(h, 8'hFF);
    chk(b, 8'hFC);
    // Reset out of stop: counter preset, flags cleared, values kept
    wr(IDX_CONTROL, ctl(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0));
    idle(20);
    rd(IDX_FLAGS, d);
    chk(d, 8'hA0);
    STOP_MODE <= 1'b1;
    idle(4);
    RSTN <= 1'b0;
    idle(2);
    RSTN <= 1'b1;
    STOP_MODE <= 1'b0;
    chk({7'h00, COMPARE_PIN}, 8'h00);
    rd(IDX_CONTROL, d);
    chk(d, 8'h00);
    rd(IDX_CNT_HI, h);
    rd(IDX_CNT_LO, b);
    chk(h, 8'hFF);
    chk(b, 8'hFC);
    rd(IDX_FLAGS, d);
    chk(d, 8'h00);
    rd(IDX_CMP_HI, d);
    chk(d, t[15:8]);
    rd(IDX_CMP_LO, d);
    chk(d, t[7:0]);
    rd(IDX_CAP_LO, d);
    chk(d, c);
    $display("test 6 done");
    end_sim;
  end

endmodule : frc_timer_test

`default_nettype wire
